// *** rcf_consts.vh ***
`ifndef RCF_CONSTS_VH
`define RCF_CONSTS_VH
// ==========================================
// Register map
`define RCF_OFS_CTRL 6'h00
`define RCF_OFS_STATUS 6'h01
`define RCF_OFS_PKTCNT 6'h02
`define RCF_CTRL_CPL_ALIGN 0
`define RCF_CTRL_RQ_ALIGN 1
`define RCF_CTRL_RESET 2'h0
`define RCF_STAT_BUSY 0
`define RCF_STAT_ALIGN 1
`define RCF_STAT_CONFLICT 2
// ==========================================
// Completion kinds
`define RCF_KIND_MEM 2'h0
`define RCF_KIND_IORD 2'h1
`define RCF_KIND_IOWR 2'h2
`define RCF_KIND_ZLR 2'h3
// ==========================================
// Error codes and fixed counts
`define RCF_ERR_FLR 4'h8
`define RCF_ERR_TIMEOUT 4'h9
`define RCF_BC_IO 13'h0004
`define RCF_BC_ZLR 13'h0001
`define RCF_DESC_DWORDS 4'h3
`define RCF_PAY_QUARTER 4'h4
`define RCF_LAST_SLOT 4'hf
`define RCF_SB_SOP_BIT 64
`endif

// *** rcf_framer.v ***
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "rcf_consts.vh"

module rcf_framer (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg pready,
   output reg [31:0] prdata,
   output reg pslverr,
   input wire cpl_hdr_valid,
   output reg cpl_hdr_ready,
   input wire [1:0] cpl_kind,
   input wire [11:0] cpl_lower_addr,
   input wire [3:0] cpl_err_code,
   input wire [12:0] cpl_byte_count,
   input wire cpl_locked,
   input wire cpl_req_done,
   input wire [10:0] cpl_dword_count,
   input wire [2:0] cpl_status,
   input wire cpl_poison,
   input wire [15:0] cpl_req_id,
   input wire [7:0] cpl_tag,
   input wire [15:0] cpl_completer_id,
   input wire [2:0] cpl_tc,
   input wire [2:0] cpl_attr,
   input wire [1:0] cpl_addr_offset,
   input wire pay_valid,
   output reg pay_ready,
   input wire [31:0] pay_data,
   input wire [3:0] pay_be,
   output reg [511:0] completion_stream_data,
   output reg [15:0] completion_stream_dword_keep,
   output reg completion_stream_valid,
   input wire completion_stream_ready,
   output reg completion_stream_last,
   output reg [64:0] completion_sideband_bus
);

   localparam ST_IDLE = 3'b001;
   localparam ST_FILL = 3'b010;
   localparam ST_SEND = 3'b100;

   // ==========================================
   // Helpers

   // Mask of dword slots 0 up to and including slot
   function [15:0] rcf_mask;
      input [3:0] slot;
      begin
         rcf_mask = ~(16'hfffe << slot);
      end
   endfunction

   // ==========================================
   // State

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [3:0] ptr_r;
   reg [3:0] ptr_nxt;
   reg [10:0] rem_r;
   reg [10:0] rem_nxt;
   reg [1:0] ctrl_r;
   reg [31:0] pkt_cnt_r;
   reg [31:0] pkt_cnt_nxt;
   reg [511:0] data_nxt;
   reg [15:0] keep_nxt;
   reg [63:0] be_nxt;
   reg sop_nxt;
   reg valid_nxt;
   reg last_nxt;
   reg hdr_ready_nxt;
   reg pay_ready_nxt;

   wire align_eff;
   wire hdr_take;
   wire pay_take;
   wire synth;
   wire apb_acc;
   wire [5:0] widx;

   // Aligned placement only when request side aligned too
   assign align_eff = ctrl_r[`RCF_CTRL_CPL_ALIGN] & ctrl_r[`RCF_CTRL_RQ_ALIGN];
   assign hdr_take = cpl_hdr_valid & cpl_hdr_ready;
   assign pay_take = pay_valid & pay_ready;
   assign synth = (cpl_err_code == `RCF_ERR_FLR) | (cpl_err_code == `RCF_ERR_TIMEOUT);
   assign apb_acc = psel & penable & pready;
   assign widx = paddr[7:2];

   // ==========================================
   // Descriptor fields

   reg [10:0] eff_dw;
   reg [12:0] eff_bc;
   reg [95:0] desc;
   reg [3:0] start_slot;

   // Effective counts and descriptor image
   always @*
   begin
      eff_dw = cpl_dword_count;
      eff_bc = cpl_byte_count;
      case (cpl_kind)
         `RCF_KIND_IORD:
         begin
            eff_dw = 11'h001;
            eff_bc = `RCF_BC_IO;
         end
         `RCF_KIND_IOWR:
         begin
            eff_dw = 11'h000;
            eff_bc = `RCF_BC_IO;
         end
         `RCF_KIND_ZLR:
         begin
            eff_dw = 11'h001;
            eff_bc = `RCF_BC_ZLR;
         end
         default:
         begin
            eff_dw = cpl_dword_count;
         end
      endcase
      if (synth)
         eff_dw = 11'h000;
      desc = 96'h0;
      desc[11:0] = cpl_lower_addr;
      desc[15:12] = cpl_err_code;
      desc[28:16] = eff_bc;
      desc[29] = cpl_locked;
      desc[30] = cpl_req_done;
      desc[42:32] = eff_dw;
      desc[45:43] = cpl_status;
      desc[46] = cpl_poison;
      desc[63:48] = cpl_req_id;
      desc[71:64] = cpl_tag;
      desc[87:72] = cpl_completer_id;
      desc[91:89] = cpl_tc;
      desc[93:92] = cpl_attr[1:0];
      // Aborted requests keep only done bit, error code, function and tag
      if (synth)
      begin
         desc = 96'h0;
         desc[30] = 1'b1;
         desc[55:48] = cpl_req_id[7:0];
         desc[71:64] = cpl_tag;
         desc[15:12] = cpl_err_code;
      end
      // First payload slot per alignment mode
      if (align_eff)
         start_slot = `RCF_PAY_QUARTER + {2'b00, cpl_addr_offset};
      else
         start_slot = `RCF_DESC_DWORDS;
   end

   // ==========================================
   // Framing state machine

   // Next state and beat image
   always @*
   begin
      state_nxt = state_r;
      ptr_nxt = ptr_r;
      rem_nxt = rem_r;
      pkt_cnt_nxt = pkt_cnt_r;
      data_nxt = completion_stream_data;
      keep_nxt = completion_stream_dword_keep;
      be_nxt = completion_sideband_bus[63:0];
      sop_nxt = completion_sideband_bus[`RCF_SB_SOP_BIT];
      valid_nxt = completion_stream_valid;
      last_nxt = completion_stream_last;
      hdr_ready_nxt = cpl_hdr_ready;
      pay_ready_nxt = pay_ready;
      case (state_r)
         ST_IDLE:
         begin
            if (hdr_take)
            begin
               // Descriptor occupies the first three dwords
               data_nxt = {416'h0, desc};
               be_nxt = 64'h0;
               sop_nxt = 1'b1;
               hdr_ready_nxt = 1'b0;
               if (cpl_kind == `RCF_KIND_ZLR && !synth)
               begin
                  // Dummy dword, all byte enables low
                  keep_nxt = rcf_mask(start_slot);
                  last_nxt = 1'b1;
                  valid_nxt = 1'b1;
                  state_nxt = ST_SEND;
               end
               else if (eff_dw == 11'h000)
               begin
                  keep_nxt = rcf_mask(`RCF_DESC_DWORDS - 4'h1);
                  last_nxt = 1'b1;
                  valid_nxt = 1'b1;
                  state_nxt = ST_SEND;
               end
               else
               begin
                  // Null dwords before payload count as kept
                  keep_nxt = rcf_mask(start_slot) >> 1;
                  ptr_nxt = start_slot;
                  rem_nxt = eff_dw;
                  last_nxt = 1'b0;
                  pay_ready_nxt = 1'b1;
                  state_nxt = ST_FILL;
               end
            end
         end
         ST_FILL:
         begin
            if (pay_take)
            begin
               data_nxt[{ptr_r, 5'b0} +: 32] = pay_data;
               be_nxt[{ptr_r, 2'b0} +: 4] = pay_be;
               keep_nxt = completion_stream_dword_keep | (16'h0001 << ptr_r);
               rem_nxt = rem_r - 11'h001;
               ptr_nxt = ptr_r + 4'h1;
               if (ptr_r == `RCF_LAST_SLOT || rem_r == 11'h001)
               begin
                  last_nxt = (rem_r == 11'h001);
                  valid_nxt = 1'b1;
                  pay_ready_nxt = 1'b0;
                  state_nxt = ST_SEND;
               end
            end
         end
         ST_SEND:
         begin
            // Beat held steady until the user takes it
            if (completion_stream_ready)
            begin
               if (completion_stream_last)
               begin
                  valid_nxt = 1'b0;
                  hdr_ready_nxt = 1'b1;
                  pkt_cnt_nxt = pkt_cnt_r + 32'h1;
                  state_nxt = ST_IDLE;
               end
               else
               begin
                  // Valid drops low between beats of one packet
                  valid_nxt = 1'b0;
                  data_nxt = 512'h0;
                  keep_nxt = 16'h0;
                  be_nxt = 64'h0;
                  sop_nxt = 1'b0;
                  ptr_nxt = 4'h0;
                  pay_ready_nxt = 1'b1;
                  state_nxt = ST_FILL;
               end
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
            valid_nxt = 1'b0;
            hdr_ready_nxt = 1'b1;
            pay_ready_nxt = 1'b0;
         end
      endcase
   end

   // Framing registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= ST_IDLE;
         ptr_r <= 4'h0;
         rem_r <= 11'h0;
         pkt_cnt_r <= 32'h0;
         completion_stream_data <= 512'h0;
         completion_stream_dword_keep <= 16'h0;
         completion_stream_valid <= 1'b0;
         completion_stream_last <= 1'b0;
         completion_sideband_bus <= 65'h0;
         cpl_hdr_ready <= 1'b1;
         pay_ready <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         ptr_r <= ptr_nxt;
         rem_r <= rem_nxt;
         pkt_cnt_r <= pkt_cnt_nxt;
         completion_stream_data <= data_nxt;
         completion_stream_dword_keep <= keep_nxt;
         completion_stream_valid <= valid_nxt;
         completion_stream_last <= last_nxt;
         completion_sideband_bus <= {sop_nxt, be_nxt};
         cpl_hdr_ready <= hdr_ready_nxt;
         pay_ready <= pay_ready_nxt;
      end
   end

   // ==========================================
   // APB slave, one wait state

   // Register read image
   reg [31:0] rd_val;
   reg rd_err;
   always @*
   begin
      rd_val = 32'h0;
      rd_err = 1'b0;
      case (widx)
         `RCF_OFS_CTRL:
            rd_val = {30'h0, ctrl_r};
         `RCF_OFS_STATUS:
         begin
            rd_val[`RCF_STAT_BUSY] = ~state_r[0];
            rd_val[`RCF_STAT_ALIGN] = align_eff;
            rd_val[`RCF_STAT_CONFLICT] = ctrl_r[`RCF_CTRL_CPL_ALIGN] & ~ctrl_r[`RCF_CTRL_RQ_ALIGN];
         end
         `RCF_OFS_PKTCNT:
            rd_val = pkt_cnt_r;
         default:
            rd_err = 1'b1;
      endcase
   end

   // Bus handshake and control register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
         ctrl_r <= `RCF_CTRL_RESET;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready)
         begin
            prdata <= pwrite ? 32'h0 : rd_val;
            pslverr <= rd_err;
         end
         else
         begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
         end
         // Mode bits are sampled only when a header is taken
         if (apb_acc && pwrite && widx == `RCF_OFS_CTRL && pstrb[0])
            ctrl_r <= pwdata[1:0];
      end
   end

endmodule // rcf_framer

// *** rcf_framer_assertions.sv ***
`timescale 1ns/1ps
// ==========================================
// Stream checker
module rcf_framer_assertions (
   input wire pclk,
   input wire presetn,
   input wire cpl_hdr_valid,
   input wire cpl_hdr_ready,
   input wire [511:0] completion_stream_data,
   input wire [15:0] completion_stream_dword_keep,
   input wire completion_stream_valid,
   input wire completion_stream_ready,
   input wire completion_stream_last,
   input wire [64:0] completion_sideband_bus
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Short aliases
   wire [511:0] d = completion_stream_data;
   wire [15:0] k = completion_stream_dword_keep;
   wire v = completion_stream_valid;
   wire sop = v && completion_sideband_bus[64];
   sequence s_hdr_take;
      cpl_hdr_valid && cpl_hdr_ready;
   endsequence
   sequence s_last_take;
      v && completion_stream_ready && completion_stream_last;
   endsequence
   a_beat_hold: assert property (v && !completion_stream_ready |=> v && $stable(d) && $stable(k))
      else $error("beat changed while stalled");
   a_desc_zero: assert property (sop |-> (d[95:88] & 8'h81) == 8'h0 && !d[47] && !d[31])
      else $error("undefined descriptor bit set");
   a_desc_keep: assert property (sop |-> k[2:0] == 3'h7)
      else $error("descriptor dwords not kept");
   a_keep_contig: assert property (v |-> (({1'b0, k} + 17'h1) & {1'b0, k}) == 17'h0)
      else $error("keep not contiguous");
   a_desc_no_be: assert property (sop |-> completion_sideband_bus[11:0] == 12'h0)
      else $error("byte enable on descriptor");
   a_sync_fields: assert property (sop && d[15:13] == 3'b100 |-> d[42:32] == 11'h0 && d[30] && completion_stream_last)
      else $error("synthetic descriptor wrong");
   a_hdr_busy: assert property (s_hdr_take |=> !cpl_hdr_ready)
      else $error("header accepted in flight");
   a_hdr_back: assert property (s_last_take |=> cpl_hdr_ready && !v)
      else $error("no return to idle");
endmodule // rcf_framer_assertions

bind rcf_framer rcf_framer_assertions u_chk (.pclk, .presetn, .cpl_hdr_valid, .cpl_hdr_ready,
   .completion_stream_data, .completion_stream_dword_keep, .completion_stream_valid,
   .completion_stream_ready, .completion_stream_last, .completion_sideband_bus);

// *** rcf_sink.sv ***
`timescale 1ns/1ps
// ==========================================
// Completion consumer
module rcf_sink (
   input wire pclk,
   input wire presetn,
   input wire stall,
   input wire [511:0] data,
   input wire [15:0] keep,
   input wire valid,
   input wire last,
   input wire [64:0] sb,
   output reg ready
);
   reg [511:0] bd_r [0:3];
   reg [15:0] bk_r [0:3];
   reg [63:0] bb_r [0:3];
   reg [3:0] bs_r;
   reg [2:0] nb_r;
   reg [2:0] cnt_r;
   reg [7:0] pc_r;
   // Stalls every other cycle on request, captures beats
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ready <= 1'b0;
         nb_r <= 3'h0;
         pc_r <= 8'h0;
      end
      else
      begin
         ready <= !stall || !ready;
         if (valid && ready)
         begin
            bd_r[nb_r] <= data;
            bk_r[nb_r] <= keep;
            bb_r[nb_r] <= sb[63:0];
            bs_r[nb_r] <= sb[64];
            nb_r <= last ? 3'h0 : nb_r + 3'h1;
            if (last)
            begin
               cnt_r <= nb_r + 3'h1;
               pc_r <= pc_r + 8'h1; // Packet count advances per packet
            end
         end
      end
   end
endmodule // rcf_sink

// *** tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
   typedef struct packed {logic [1:0] md; logic [1:0] kd; logic [3:0] er; logic [12:0] bc;
      logic [10:0] dw; logic [2:0] st; logic [1:0] of; logic [2:0] fl;} rcf_row_t;
   rcf_row_t rows [0:11];
   int compares = 0;
   int bad_count = 0;
   int i;
   logic [31:0] q;
   logic e;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;
   logic cpl_hdr_valid = 0, cpl_locked = 0, cpl_req_done = 0, cpl_poison = 0, pay_valid = 0;
   logic [7:0] paddr = 0, cpl_tag = 0;
   logic [31:0] pwdata = 0, pay_data = 0;
   logic [3:0] cpl_err_code = 0, pay_be = 0;
   logic [1:0] cpl_kind = 0, cpl_addr_offset = 0;
   logic [11:0] cpl_lower_addr = 0;
   logic [12:0] cpl_byte_count = 0;
   logic [10:0] cpl_dword_count = 0;
   logic [2:0] cpl_status = 0;
   logic [15:0] cpl_req_id = 0;
   wire pready, pslverr, cpl_hdr_ready, pay_ready;
   wire completion_stream_valid, completion_stream_ready, completion_stream_last;
   wire [31:0] prdata;
   wire [511:0] completion_stream_data;
   wire [15:0] completion_stream_dword_keep;
   wire [64:0] completion_sideband_bus;

   rcf_framer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .pready,
      .prdata, .pslverr, .cpl_hdr_valid, .cpl_hdr_ready, .cpl_kind, .cpl_lower_addr, .cpl_err_code,
      .cpl_byte_count, .cpl_locked, .cpl_req_done, .cpl_dword_count, .cpl_status, .cpl_poison,
      .cpl_req_id, .cpl_tag, .cpl_completer_id(16'hc0de), .cpl_tc(3'h5), .cpl_attr(3'h7),
      .cpl_addr_offset, .pay_valid, .pay_ready, .pay_data, .pay_be, .completion_stream_data,
      .completion_stream_dword_keep, .completion_stream_valid, .completion_stream_ready,
      .completion_stream_last, .completion_sideband_bus);
   rcf_sink u_sink (.pclk, .presetn, .stall, .data(completion_stream_data),
      .keep(completion_stream_dword_keep), .valid(completion_stream_valid),
      .last(completion_stream_last), .sb(completion_sideband_bus), .ready(completion_stream_ready));

   // Clock
   always #2.5 pclk = ~pclk;

   // ==========================================
   // Bus and packet tasks
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
      output logic er);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   task automatic send(input rcf_row_t r, input logic [7:0] t);
      logic [95:0] ed;
      logic [15:0] ek [0:3];
      logic [63:0] eb [0:3];
      int s, st0, pl, n0;
      n0 = u_sink.pc_r;
      st0 = (r.md == 2'h3) ? 4 + r.of : 3;
      pl = r.er[3] ? 0 : (r.kd == 2'h0) ? r.dw : (r.kd == 2'h2) ? 0 : 1;
      ed = {4'h3, 3'h5, 1'b0, 16'hc0de, t, 8'h21, t, 1'b0, r.fl[0], r.st,
         (r.kd == 2'h0) ? r.dw : {10'h0, r.kd != 2'h2}, 1'b0, r.fl[1], r.fl[2],
         (r.kd == 2'h0) ? r.bc : (r.kd == 2'h3) ? 13'h1 : 13'h4, r.er, 4'ha, t};
      if (r.er[3])
         ed = {24'h0, t, 8'h0, t, 17'h0, 1'b1, 14'h0, r.er, 12'h0};
      {cpl_kind, cpl_err_code, cpl_byte_count, cpl_dword_count, cpl_status, cpl_addr_offset} <=
         {r.kd, r.er, r.bc, r.dw, r.st, r.of};
      {cpl_locked, cpl_req_done, cpl_poison} <= r.fl;
      {cpl_tag, cpl_req_id, cpl_lower_addr, cpl_hdr_valid} <= {t, 8'h21, t, 4'ha, t, 1'b1};
      do @(posedge pclk); while (cpl_hdr_ready !== 1'b1);
      cpl_hdr_valid <= 1'b0;
      for (s = 0; s < pl - (r.kd == 2'h3); s++)
      begin
         {pay_valid, pay_data, pay_be} <= {1'b1, t, 24'(s), 4'hf - 4'(s % 4)};
         do @(posedge pclk); while (pay_ready !== 1'b1);
      end
      pay_valid <= 1'b0;
      for (s = 0; s < 100 && u_sink.pc_r == 8'(n0); s++) @(posedge pclk);
      `CHK("packets", 8'(n0 + 1), u_sink.pc_r)
      for (s = 0; s < 4; s++)
         {ek[s], eb[s]} = 80'h0;
      // Expected slot map
      for (s = 0; s < st0 + pl; s++)
      begin
         ek[s / 16][s % 16] = 1'b1;
         if (s >= st0 && r.kd != 2'h3)
         begin
            eb[s / 16][4 * (s % 16) +: 4] = 4'hf - 4'((s - st0) % 4);
            `CHK("payload", {t, 24'(s - st0)}, u_sink.bd_r[s / 16][32 * (s % 16) +: 32])
         end
      end
      `CHK("beats", 3'((st0 + pl + 15) / 16), u_sink.cnt_r)
      `CHK("descriptor", ed, u_sink.bd_r[0][95:0])
      if (r.er != 4'h0)
         `CHK("err_addr", r.er[3] ? 7'h0 : t[6:0], u_sink.bd_r[0][6:0])
      for (s = 0; s < (st0 + pl + 15) / 16; s++)
      begin
         `CHK("keep", ek[s], u_sink.bk_r[s])
         `CHK("byte_en", eb[s], u_sink.bb_r[s])
         `CHK("start", s == 0, u_sink.bs_r[s])
      end
   endtask

   task test_done;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      rows = '{'{0, 0, 0, 20, 2, 0, 0, 0}, '{0, 0, 0, 12, 3, 0, 0, 2}, '{0, 1, 1, 0, 0, 0, 0, 3},
         '{0, 2, 2, 0, 0, 1, 0, 2}, '{0, 3, 3, 0, 0, 2, 0, 2}, '{0, 0, 4, 4, 1, 4, 0, 4},
         '{0, 0, 5, 52, 13, 0, 0, 2}, '{1, 0, 6, 56, 14, 0, 0, 2}, '{0, 0, 8, 0, 5, 0, 0, 0},
         '{0, 0, 9, 0, 0, 0, 0, 0}, '{3, 0, 0, 56, 14, 0, 1, 2}, '{3, 0, 0, 8, 2, 0, 3, 2}};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0, q, e);
      `CHK("ctrl_reset", 32'h0, q)
      apb(1'b1, 8'h08, 32'hff, q, e);
      apb(1'b0, 8'h0c, 32'h0, q, e);
      `CHK("unmapped", 1'b1, e)
      for (i = 0; i < 12; i++)
      begin
         stall <= i[0];
         apb(1'b1, 8'h00, {30'h0, rows[i].md}, q, e);
         apb(1'b0, 8'h04, 32'h0, q, e);
         `CHK("status", {rows[i].md == 2'h1, rows[i].md == 2'h3, 1'b0}, q[2:0])
         send(rows[i], 8'h40 + 8'(i));
      end
      apb(1'b0, 8'h08, 32'h0, q, e);
      `CHK("pkt_count", 32'd12, q)
      // Reset while a packet waits for payload
      cpl_hdr_valid <= 1'b1;
      do @(posedge pclk); while (cpl_hdr_ready !== 1'b1);
      cpl_hdr_valid <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      `CHK("abort_hdr_ready", 1'b1, cpl_hdr_ready)
      `CHK("abort_valid", 1'b0, completion_stream_valid)
      presetn <= 1'b1;
      send(rows[0], 8'h7f);
      test_done;
   end

   // Watchdog
   initial
   begin
      #100000;
      bad_count++;
      test_done;
   end
endmodule // tb_top
